// >>> hdl/ddmp_cfg.svh
// Constants for the memory-side command decoder and mode register block
`ifndef DDMP_CFG_SVH
`define DDMP_CFG_SVH

// ****************************************************************
// Bus register offsets (byte addresses)
// ****************************************************************
`define DDMP_OFF_MODE      12'h000
`define DDMP_OFF_EXT       12'h004
`define DDMP_OFF_STATUS    12'h008
`define DDMP_OFF_CTRL      12'h00c
`define DDMP_OFF_WDATA     12'h010
`define DDMP_OFF_WADDR     12'h014

// ****************************************************************
// Mode register fields
// ****************************************************************
`define DDMP_MR_BL_LSB     0
`define DDMP_MR_BL_MSB     2
`define DDMP_MR_AM_BIT     3
`define DDMP_MR_LAT_LSB    4
`define DDMP_MR_LAT_MSB    6
`define DDMP_MR_TEST_BIT   7
`define DDMP_MR_DLLRST_BIT 8
`define DDMP_AP_BIT        8

// ****************************************************************
// Extended mode register fields
// ****************************************************************
`define DDMP_EMR_DLL_BIT   0
`define DDMP_EMR_DS0_BIT   1
`define DDMP_EMR_DS1_BIT   6

// ****************************************************************
// Field codes
// ****************************************************************
`define DDMP_BL2           3'h1
`define DDMP_BL4           3'h2
`define DDMP_BL8           3'h3
`define DDMP_LAT3          3'h3

// ****************************************************************
// Timing
// ****************************************************************
`define DDMP_CLK_MHZ       25
`define DDMP_DLL_LOCK_CYC  200
`define DDMP_MRW_BUSY_CYC  2

`endif

// >>> hdl/ddmp_pkg.sv
// Types shared by the command decoder and mode register block
package ddmp_pkg;

  typedef enum logic [2:0] {
    ddmp_cmd_nop,
    ddmp_cmd_mode_write,
    ddmp_cmd_ext_write,
    ddmp_cmd_activate,
    ddmp_cmd_column,
    ddmp_cmd_precharge,
    ddmp_cmd_refresh,
    ddmp_cmd_other
  } ddmp_cmd_t;

  typedef struct packed {
    logic        cke;
    logic        select_n;
    logic        row_strobe_n;
    logic        col_strobe_n;
    logic        write_strobe_n;
    logic [1:0]  bank_select;
    logic [11:0] multiplexed_address;
  } ddmp_cmd_bus_t;

  typedef struct packed {
    ddmp_cmd_t   cmd;
    logic [1:0]  bank;
    logic [11:0] addr;
  } ddmp_dec_t;

  typedef struct packed {
    logic [2:0] burst_code;
    logic       interleaved;
    logic [2:0] latency_code;
    logic       test_mode;
    logic       dll_reset;
  } ddmp_mode_t;

endpackage

// >>> hdl/ddmp_cmd_decode.sv
// Command decoder: samples control pins on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module ddmp_cmd_decode
  import ddmp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire ddmp_pkg::ddmp_cmd_bus_t pins,
  output ddmp_pkg::ddmp_dec_t dec
);
  import ddmp_pkg::*;

  function automatic ddmp_cmd_t decode(input logic [3:0] c, input logic ba0);
    case (c)
      4'h0:    decode = ba0 ? ddmp_cmd_ext_write : ddmp_cmd_mode_write;
      4'h3:    decode = ddmp_cmd_activate;
      4'h4,
      4'h5:    decode = ddmp_cmd_column;
      4'h2:    decode = ddmp_cmd_precharge;
      4'h1:    decode = ddmp_cmd_refresh;
      4'h7:    decode = ddmp_cmd_nop;
      default: decode = ddmp_cmd_other;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec <= '0;
    end else if (!pins.cke || pins.select_n) begin
      // Clock stopped or decoder deselected: new commands are ignored
      dec <= '{cmd: ddmp_cmd_nop, bank: 2'h0, addr: 12'h000};
    end else begin
      dec.cmd  <= decode({pins.select_n, pins.row_strobe_n, pins.col_strobe_n,
                          pins.write_strobe_n}, pins.bank_select[0]);
      dec.bank <= pins.bank_select;
      dec.addr <= pins.multiplexed_address;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ddmp_write_mask.sv
// Byte lane masking of write data, zero latency to its data
`timescale 1ns/10ps
`default_nettype none
module ddmp_write_mask #(
  parameter int LANES = 4
) (
  input  wire logic [8*LANES-1:0] old_word,
  input  wire logic [8*LANES-1:0] data_lines,
  input  wire logic [LANES-1:0]   byte_write_mask,
  output logic      [8*LANES-1:0] merged
);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      // Lane g covers data bits 8g..8g+7, lowest lane first
      assign merged[8*g+:8] = byte_write_mask[g] ? old_word[8*g+:8] : data_lines[8*g+:8];
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hdl/ddmp_top.sv
// Memory-side command, mode register and write mask block with AXI4-Lite view
//
// Function
// - Commands sampled rising edge; data on strobe (this block takes data once per clock)
// - Clock enable low stops internal clock (here: decoder gives NOP, write word holds, counters keep running)
// - Select high ignores new commands
// - Mask bit high blocks its byte lane
// - Row 12 bits, column 8, bit8 precharge
// - All strobes low writes mode register
// - Mode fields: burst, order, latency, test
// - Mode register undefined until written
// - Bank bit0 high writes extended register
// - Extended: DLL enable, driver strength
// - Bursts 2,4,8; both orders; latency 3
`timescale 1ns/10ps
`default_nettype none
`include "ddmp_cfg.svh"
module ddmp_top
  import ddmp_pkg::*;
#(
  parameter int ROWS_BITS = 12,
  parameter int COL_BITS  = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire ddmp_pkg::ddmp_cmd_bus_t pins,
  input  wire logic [31:0]         data_lines,
  input  wire logic [3:0]          byte_write_mask,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [11:0]         s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     dll_locked,
  output logic                     mode_valid,
  output logic [3:0]               burst_words,
  output logic                     auto_precharge_flag,
  output logic [ROWS_BITS-1:0]     row_address,
  output logic [COL_BITS-1:0]      column_address,
  output logic [1:0]               active_bank
);
  import ddmp_pkg::*;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  ddmp_dec_t  dec;
  ddmp_mode_t mode;
  logic [11:0] ext_reg;
  logic        ext_bank1;
  logic        ext_valid;
  logic [3:0]  banks_open;
  logic [1:0]  busy_cnt;
  logic [7:0]  lock_cnt;
  logic        proto_err;
  logic [31:0] last_word;
  logic [31:0] wr_word;

  ddmp_cmd_decode u_dec (
    .clk   (clk),
    .rst_n (rst_n),
    .pins  (pins),
    .dec   (dec)
  );

  function automatic logic [3:0] burst_len(input logic [2:0] code);
    case (code)
      `DDMP_BL2: burst_len = 4'h2;
      `DDMP_BL4: burst_len = 4'h4;
      `DDMP_BL8: burst_len = 4'h8;
      default:   burst_len = 4'h0;
    endcase
  endfunction

  wire logic mode_hit = dec.cmd == ddmp_cmd_mode_write;
  wire logic ext_hit  = dec.cmd == ddmp_cmd_ext_write;

  // ****************************************************************
  // Mode and extended mode registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode       <= '0; // Contents have no meaning until mode_valid
      mode_valid <= 1'b0;
    end else if (mode_hit) begin
      mode.burst_code   <= dec.addr[`DDMP_MR_BL_MSB:`DDMP_MR_BL_LSB];
      mode.interleaved  <= dec.addr[`DDMP_MR_AM_BIT];
      mode.latency_code <= dec.addr[`DDMP_MR_LAT_MSB:`DDMP_MR_LAT_LSB];
      mode.test_mode    <= dec.addr[`DDMP_MR_TEST_BIT];
      mode.dll_reset    <= dec.addr[`DDMP_MR_DLLRST_BIT];
      mode_valid        <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_reg   <= 12'h000;
      ext_bank1 <= 1'b0;
      ext_valid <= 1'b0;
    end else if (ext_hit) begin
      ext_reg   <= dec.addr;
      ext_bank1 <= dec.bank[1];
      ext_valid <= 1'b1;
    end
  end

  // ****************************************************************
  // DLL lock counter
  // ****************************************************************
  // Restarts on every DLL-reset mode write; an extended write that turns the DLL off drops the lock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_cnt   <= 8'h00;
      dll_locked <= 1'b0;
    end else if (mode_hit && dec.addr[`DDMP_MR_DLLRST_BIT]) begin
      lock_cnt   <= 8'h00;
      dll_locked <= 1'b0;
    end else if (ext_hit && dec.addr[`DDMP_EMR_DLL_BIT]) begin
      dll_locked <= 1'b0;
    end else if (ext_valid && !ext_reg[`DDMP_EMR_DLL_BIT] && mode_valid) begin
      if (lock_cnt != 8'(`DDMP_DLL_LOCK_CYC - 1)) begin
        lock_cnt <= lock_cnt + 8'h01;
      end else begin
        dll_locked <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Bank state, busy window and sequence checks
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      banks_open <= 4'h0;
    end else if (dec.cmd == ddmp_cmd_activate) begin
      banks_open[dec.bank] <= 1'b1;
    end else if (dec.cmd == ddmp_cmd_precharge) begin
      if (dec.addr[`DDMP_AP_BIT]) begin
        banks_open <= 4'h0;
      end else begin
        banks_open[dec.bank] <= 1'b0;
      end
    end else if (dec.cmd == ddmp_cmd_column && dec.addr[`DDMP_AP_BIT]) begin
      banks_open[dec.bank] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_cnt <= 2'h0;
    end else if (mode_hit || ext_hit) begin
      busy_cnt <= 2'(`DDMP_MRW_BUSY_CYC);
    end else if (busy_cnt != 2'h0) begin
      busy_cnt <= busy_cnt - 2'h1;
    end
  end

  // Sticky flag for controller mistakes; the device still obeys the command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      proto_err <= 1'b0;
    end else if ((mode_hit || ext_hit) && banks_open != 4'h0) begin
      proto_err <= 1'b1;
    end else if (dec.cmd != ddmp_cmd_nop && busy_cnt != 2'h0) begin
      proto_err <= 1'b1;
    end else if (mode_hit && (dec.addr[`DDMP_MR_TEST_BIT] || dec.bank != 2'h0)) begin
      proto_err <= 1'b1;
    end else if (ext_hit && (dec.addr & 12'hfbc) != 12'h000) begin
      proto_err <= 1'b1;
    end else if (s_axi_awvalid && s_axi_wvalid && s_axi_awready
                 && s_axi_awaddr == `DDMP_OFF_CTRL && s_axi_wstrb[0] && s_axi_wdata[0]) begin
      proto_err <= 1'b0;
    end
  end

  // ****************************************************************
  // Row/column capture and masked write data
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      row_address         <= '0;
      column_address      <= '0;
      auto_precharge_flag <= 1'b0;
      active_bank         <= 2'h0;
      burst_words         <= 4'h0;
    end else begin
      burst_words <= burst_len(mode.burst_code);
      if (dec.cmd == ddmp_cmd_activate) begin
        row_address <= dec.addr[ROWS_BITS-1:0];
        active_bank <= dec.bank;
      end else if (dec.cmd == ddmp_cmd_column) begin
        column_address      <= dec.addr[COL_BITS-1:0];
        auto_precharge_flag <= dec.addr[`DDMP_AP_BIT];
        active_bank         <= dec.bank;
      end
    end
  end

  // Data is taken once per clock here; the strobe-edge capture lives in the PHY ahead of this block
  ddmp_write_mask #(.LANES(4)) u_mask (
    .old_word        (last_word),
    .data_lines      (data_lines),
    .byte_write_mask (byte_write_mask),
    .merged          (wr_word)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_word <= 32'h0000_0000;
    end else if (pins.cke) begin
      last_word <= wr_word;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  wire logic wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= wr_take;
      s_axi_wready  <= wr_take;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr == `DDMP_OFF_CTRL) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `DDMP_OFF_MODE:   s_axi_rdata <= {23'h0, mode};
          `DDMP_OFF_EXT:    s_axi_rdata <= {19'h0, ext_bank1, ext_reg};
          `DDMP_OFF_STATUS: s_axi_rdata <= {24'h0, proto_err, banks_open,
                                            ext_valid, mode_valid, dll_locked};
          `DDMP_OFF_CTRL:   s_axi_rdata <= 32'h0000_0000;
          `DDMP_OFF_WDATA:  s_axi_rdata <= last_word;
          `DDMP_OFF_WADDR:  s_axi_rdata <= {18'h0, active_bank, 3'h0,
                                            auto_precharge_flag, column_address};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> tb/ddmp_top_sva.sv
// Checker for command capture and register bus timing of the mode block
`timescale 1ns/10ps
`default_nettype none
module ddmp_top_sva #(
  parameter int ROWS_BITS = 12,
  parameter int COL_BITS  = 8
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire ddmp_pkg::ddmp_cmd_bus_t pins,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    dll_locked,
  input wire logic                    mode_valid,
  input wire logic [3:0]              burst_words,
  input wire logic                    auto_precharge_flag,
  input wire logic [ROWS_BITS-1:0]    row_address,
  input wire logic [COL_BITS-1:0]     column_address,
  input wire logic [1:0]              active_bank
);
  import ddmp_pkg::*;
  // ****************************************
  // Command view of the pins
  // ****************************************
  wire       on_bus   = pins.cke && !pins.select_n;
  wire [2:0] rcw      = {pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n};
  wire       mode_cmd = on_bus && rcw == 3'h0 && !pins.bank_select[0];
  wire       act_cmd  = on_bus && rcw == 3'h3;
  wire       col_cmd  = on_bus && rcw[2:1] == 2'h2;
  wire       addr_cmd = act_cmd || col_cmd;
  logic [2:0] held_code;
  logic [8:0] since_rst;
  always_ff @(posedge clk) begin
    if (!rst_n) held_code <= 3'h0;
    else if (mode_cmd) held_code <= pins.multiplexed_address[2:0];
  end
  // Saturates so a long idle stretch never wraps into a false early count
  always_ff @(posedge clk) begin
    if (!rst_n) since_rst <= 9'h000;
    else if (mode_cmd && pins.multiplexed_address[8]) since_rst <= 9'h000;
    else if (since_rst != 9'h1ff) since_rst <= since_rst + 9'h001;
  end
  function automatic logic [3:0] words_of(input logic [2:0] c);
    return (c == 3'h0 || c > 3'h3) ? 4'h0 : 4'h1 << c;
  endfunction
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_mode_alone;
    mode_cmd ##1 (!mode_cmd) [*3];
  endsequence
  sequence s_blocked;
    (!mode_valid && !on_bus) [*3];
  endsequence
  sequence s_act_alone;
    act_cmd ##1 (!addr_cmd) [*2];
  endsequence
  sequence s_col_alone;
    col_cmd ##1 (!addr_cmd) [*2];
  endsequence
  a_mode_sets_valid: assert property (mode_cmd |-> ##[2:3] mode_valid)
    else $error("mode_valid not set after mode write");
  a_blocked_ignored: assert property (s_blocked |=> !mode_valid)
    else $error("command taken while disabled");
  a_burst_decode: assert property (s_mode_alone |=> burst_words == words_of(held_code))
    else $error("burst_words wrong for mode code");
  a_row_capture: assert property (s_act_alone |=> row_address == $past(pins.multiplexed_address, 3)
    && active_bank == $past(pins.bank_select, 3))
    else $error("row or bank not captured");
  a_col_capture: assert property (s_col_alone |=> column_address == $past(pins.multiplexed_address[7:0], 3)
    && auto_precharge_flag == $past(pins.multiplexed_address[8], 3))
    else $error("column or precharge flag not captured");
  a_dll_wait: assert property ($rose(dll_locked) |-> since_rst >= 9'h0c7)
    else $error("dll_locked rose too early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |-> ##1 (s_axi_awready && s_axi_wready) ##1 s_axi_bvalid)
    else $error("write answer out of order");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |-> ##1 s_axi_arready ##1 s_axi_rvalid)
    else $error("read answer out of order");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
`default_nettype wire

// >>> tb/ddmp_ctl_model.sv
// Behavioural memory controller driving the command and data pins
`timescale 1ns/10ps
`default_nettype none
module ddmp_ctl_model #(
  parameter int PWR_CYC = 5000
) (
  input wire logic                clk,
  output ddmp_pkg::ddmp_cmd_bus_t pins,
  output logic [31:0]             data_lines,
  output logic [3:0]              byte_write_mask
);
  import ddmp_pkg::*;
  // ****************************************
  // Pin drive
  // ****************************************
  initial begin
    pins = {1'b0, 4'hf, 2'h0, 12'h000};
    data_lines = 32'h0f0f0f0f;
    byte_write_mask = 4'h0;
  end
  // Idle data keeps moving so nothing can lean on a held value
  always @(posedge clk) begin
    data_lines <= ~data_lines;
    byte_write_mask <= byte_write_mask + 4'h1;
  end
  // One command cycle, then gap cycles of no-operation with enable high
  task automatic issue(input logic cke, input logic sel_n, input logic [2:0] rcw,
                       input logic [1:0] ba, input logic [11:0] a, input int gap);
    pins <= {cke, sel_n, rcw, ba, a};
    @(posedge clk);
    if (gap > 0) begin
      pins <= {1'b1, 1'b0, 3'h7, ~ba, ~a};
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic power_up(input logic [11:0] ext_a, input logic [11:0] mode_a);
    repeat (PWR_CYC) @(posedge clk);
    issue(1'b1, 1'b0, 3'h7, 2'h0, 12'h000, 1);
    issue(1'b1, 1'b0, 3'h2, 2'h0, 12'h100, 2);
    issue(1'b1, 1'b0, 3'h0, 2'h1, ext_a, 2);
    issue(1'b1, 1'b0, 3'h0, 2'h0, mode_a | 12'h100, 2);
    issue(1'b1, 1'b0, 3'h2, 2'h0, 12'h100, 2);
    repeat (2) issue(1'b1, 1'b0, 3'h1, 2'h0, 12'h000, 2);
    repeat (200) @(posedge clk);
    issue(1'b1, 1'b0, 3'h0, 2'h0, mode_a & 12'h07f, 2);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_ddmp_top.sv
// Self-checking testbench for the command decoder and mode register block
`timescale 1ns/10ps
`default_nettype none
`include "ddmp_cfg.svh"
module tb_ddmp_top;
  import ddmp_pkg::*;
  logic          clk, rst_n, dll_locked, mode_valid, auto_precharge_flag;
  ddmp_cmd_bus_t pins;
  logic [31:0]   data_lines, s_axi_wdata, s_axi_rdata, ref_word, ref_snap;
  logic [3:0]    byte_write_mask, s_axi_wstrb, burst_words;
  logic [11:0]   s_axi_awaddr, s_axi_araddr, row_address;
  logic [1:0]    s_axi_bresp, s_axi_rresp, active_bank;
  logic [7:0]    column_address;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int            err_total, samples_checked;
  ddmp_top u_ddmp_top (
    .clk, .rst_n, .pins, .data_lines, .byte_write_mask,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .dll_locked, .mode_valid, .burst_words,
    .auto_precharge_flag, .row_address, .column_address, .active_bank
  );
  ddmp_ctl_model u_ddmp_ctl_model (.clk, .pins, .data_lines, .byte_write_mask);
  // Reference for the last masked word: a lane follows its data only while its mask bit is low
  always @(posedge clk) begin
    if (!rst_n) begin
      ref_word <= 32'h0000_0000;
    end else if (pins.cke) begin
      for (int k = 0; k < 4; k++) begin
        if (!byte_write_mask[k]) ref_word[8*k+:8] <= data_lines[8*k+:8];
      end
    end
    if (s_axi_arready) ref_snap <= ref_word;
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic limit(input int n);
    if (n >= 100) begin
      chk(32'h1, 32'h0);
      stop_test();
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_due, w_due;
    int n;
    aw_due = 1'b1;
    w_due = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((aw_due || w_due) && n < 50) begin
      @(posedge clk);
      if (s_axi_awready) aw_due = 1'b0;
      if (s_axi_wready) w_due = 1'b0;
      s_axi_awvalid <= aw_due;
      s_axi_wvalid <= w_due;
      n++;
    end
    // Late ready exercises the slave holding its response
    @(posedge clk);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    limit(n);
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [1:0] r, output logic [31:0] d);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    limit(n);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, 2'h0, d);
    chk(d & m, e);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init;
    chk(32'({mode_valid, burst_words, dll_locked}), 32'h0);
    u_ddmp_ctl_model.power_up(12'h042, 12'h032);
    repeat (3) @(posedge clk);
    chk(32'({mode_valid, burst_words}), 32'h14);
    rd_chk(`DDMP_OFF_MODE, 32'h1ff, 32'(ddmp_mode_t'{3'h2, 1'b0, 3'h3, 1'b0, 1'b0}));
    rd_chk(`DDMP_OFF_EXT, 32'h1fff, 32'h042);
    rd_chk(`DDMP_OFF_STATUS, 32'hff, 32'h07);
  endtask
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h0, 2'h0, {5'h00, 3'h3, i[2], ~i[2], i[1:0]}, 2);
      rd_chk(`DDMP_OFF_MODE, 32'h1ff, 32'(ddmp_mode_t'{{~i[2], i[1:0]}, i[2], 3'h3, 1'b0, 1'b0}));
      chk(32'(burst_words), 32'(i > 4 ? 1 << (i - 4) : 0));
    end
  endtask
  task automatic t_refused;
    u_ddmp_ctl_model.issue(1'b1, 1'b1, 3'h0, 2'h0, 12'h032, 2);
    u_ddmp_ctl_model.issue(1'b0, 1'b0, 3'h0, 2'h0, 12'h032, 2);
    rd_chk(`DDMP_OFF_MODE, 32'h1ff, 32'(ddmp_mode_t'{3'h3, 1'b1, 3'h3, 1'b0, 1'b0}));
    chk(32'(burst_words), 32'h8);
  endtask
  task automatic t_addr;
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h3, 2'h2, 12'habc, 2);
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h5, 2'h2, 12'h15a, 3);
    chk(32'({row_address, active_bank, column_address, auto_precharge_flag}), {9'h0, 12'habc, 2'h2, 8'h5a, 1'b1});
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h4, 2'h2, 12'h0a5, 3);
    chk(32'({row_address, active_bank, column_address, auto_precharge_flag}), {9'h0, 12'habc, 2'h2, 8'ha5, 1'b0});
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h2, 2'h0, 12'h100, 2);
  endtask
  task automatic t_bus;
    logic [31:0] d;
    // Command right behind a mode write is flagged, then cleared by software
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h0, 2'h0, 12'h032, 0);
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h2, 2'h0, 12'h100, 2);
    rd_chk(`DDMP_OFF_STATUS, 32'h80, 32'h80);
    axi_wr(`DDMP_OFF_CTRL, 32'h1, 2'h0);
    rd_chk(`DDMP_OFF_STATUS, 32'h80, 32'h0);
    axi_wr(`DDMP_OFF_MODE, 32'h0, 2'h2);
    axi_rd(12'h020, 2'h2, d);
    chk(d, 32'h0);
    axi_rd(`DDMP_OFF_WDATA, 2'h0, d);
    chk(d, ref_snap);
    // A fresh DLL reset drops the lock until the relock time has passed
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h0, 2'h0, 12'h132, 2);
    chk(32'(dll_locked), 32'h0);
    repeat (`DDMP_DLL_LOCK_CYC - 1) @(posedge clk);
    chk(32'(dll_locked), 32'h0);
    @(posedge clk);
    chk(32'(dll_locked), 32'h1);
    u_ddmp_ctl_model.issue(1'b1, 1'b0, 3'h0, 2'h0, 12'h032, 2);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_codes();
    t_refused();
    t_addr();
    t_bus();
    stop_test();
  end
endmodule
bind ddmp_top ddmp_top_sva #(.ROWS_BITS(ROWS_BITS), .COL_BITS(COL_BITS)) u_ddmp_top_sva (
  .clk, .rst_n, .pins, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .dll_locked, .mode_valid, .burst_words, .auto_precharge_flag,
  .row_address, .column_address, .active_bank
);
`default_nettype wire
